// *** hw/i2cm_pkg.sv ***
// Package for the two-wire register master: timing and address constants.
// Assumes a 25 MHz system clock driving the master.
package i2cm_pkg;
  // ****************************************************************
  // Clock and bus timing
  // ****************************************************************
  localparam int SYS_CLK_HZ = 25000000; // System clock rate
  localparam int STD_BUS_HZ = 100000; // Standard bus speed
  localparam int FAST_BUS_HZ = 400000; // Fast bus speed
  // Quarter period counts, rounded up so the bus never runs above its mode's rate
  localparam int STD_QTR_CYC = (SYS_CLK_HZ + 4 * STD_BUS_HZ - 1) / (4 * STD_BUS_HZ);
  localparam int FAST_QTR_CYC = (SYS_CLK_HZ + 4 * FAST_BUS_HZ - 1) / (4 * FAST_BUS_HZ);
  // ****************************************************************
  // Slave address
  // ****************************************************************
  localparam logic [4:0] SLV_PREFIX = 5'h12; // Fixed upper five address bits
  localparam logic DIR_WRITE = 1'b0; // Write direction bit
  localparam logic DIR_READ = 1'b1; // Read direction bit
  // ****************************************************************
  // Command codes
  // ****************************************************************
  typedef enum logic [1:0] {
    I2CM_CMD_WRITE = 2'h0, // Pointer set then one data byte
    I2CM_CMD_READ = 2'h1, // Pointer set, repeated start, read byte
    I2CM_CMD_REREAD = 2'h2 // Read from the kept pointer only
  } i2cm_cmd_t;
endpackage

// *** hw/i2cm_master.sv ***
// Two-wire master that writes and reads the byte registers of an addressed slave.
// Assumes open-drain wires with pull-ups resolved by the surrounding bench.
//
// Behaviour
// - Data changes only while clock low
// - Start/stop by data edge while clock high
// - Seven-bit address, prefix plus select pins
// - Write direction zero, slave acknowledges it
// - Eight-bit register address, acknowledged, MSB first
// - One data byte stored, acknowledged
// - After write: stop or repeated start
// - Read: repeated start, address, direction one
// - Slave shifts byte; master acknowledges it
// - After read: stop; reread skips pointer
// - Repeated start: data up, clock up, data down
// - Slave drives data only at ack/read
`timescale 1ns/1ps
module i2cm_master
  import i2cm_pkg::*;
#(
  parameter int QTR_STD = STD_QTR_CYC, // Quarter bit count, standard speed
  parameter int QTR_FAST = FAST_QTR_CYC // Quarter bit count, fast speed
) (
  input wire logic sys_clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic fast_i, // Select fast bus speed
  input wire logic cmd_valid_i, // Command request
  output logic cmd_ready_o, // Idle and able to take a command
  input wire logic [1:0] cmd_op_i, // Command code
  input wire logic [1:0] cmd_sel_i, // Slave address select bits
  input wire logic [7:0] cmd_reg_i, // Register address
  input wire logic [7:0] cmd_wdata_i, // Write data
  output logic done_o, // Command finished pulse
  output logic nack_o, // Slave failed to acknowledge
  output logic [7:0] rdata_o, // Read data
  output logic scl_o, // Clock pin output value
  output logic scl_oe_o, // Clock pin driven low when high
  input wire logic sda_i, // Data pin level
  output logic sda_o, // Data pin output value
  output logic sda_oe_o // Data pin driven low when high
);
  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (QTR_STD < 2 || QTR_FAST < 2 || QTR_FAST > QTR_STD || QTR_STD > 65536) begin : g_chk
    $error("Quarter counts out of range");
  end
  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  logic [2:0] sda_sync_q; // Three stage data sampler
  logic sda_in_q; // Filtered data level
  logic sda_in_d;
  always_comb begin
    // Accept change once stages two and three agree
    sda_in_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_in_q;
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sda_sync_q <= 3'h7;
      sda_in_q <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      sda_in_q <= sda_in_d;
    end
  end
  // ****************************************************************
  // Quarter bit tick divider
  // ****************************************************************
  logic [15:0] div_q; // Divider count
  logic [15:0] div_d;
  logic tick; // One-cycle quarter bit enable
  logic [15:0] qtr_lim; // Active quarter count
  always_comb begin
    // Speed choice
    qtr_lim = fast_i ? 16'(QTR_FAST - 1) : 16'(QTR_STD - 1);
    tick = (div_q >= qtr_lim);
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) div_q <= 16'h0000;
    else div_q <= div_d;
  end
  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  typedef enum logic [3:0] {
    I2CM_IDLE = 4'h0, // Bus free
    I2CM_START = 4'h1, // Start or repeated start
    I2CM_BIT = 4'h3, // Eight bits of a byte
    I2CM_ACK = 4'h2, // Ninth bit
    I2CM_STOP = 4'h6, // Stop condition
    I2CM_DONE = 4'h4 // Report
  } i2cm_state_t;
  i2cm_state_t st_q, st_d; // Sequencer state
  logic [1:0] ph_q, ph_d; // Quarter phase within bit
  logic [2:0] bit_q, bit_d; // Bit index, MSB first
  logic [1:0] byte_q, byte_d; // Byte index within phase
  logic [7:0] sh_q, sh_d; // Shift register
  logic scl_q, scl_d; // Clock level requested
  logic sdo_q, sdo_d; // Data level requested
  logic rd_q, rd_d; // Current phase reads
  logic [1:0] op_q, op_d; // Latched command
  logic [1:0] sel_q, sel_d; // Latched select bits
  logic [7:0] reg_q, reg_d; // Latched register
  logic [7:0] wd_q, wd_d; // Latched write data
  logic [7:0] rdat_q, rdat_d; // Read result
  logic nack_q, nack_d; // No acknowledge seen
  logic [7:0] addr_byte; // Address plus direction
  // Address with direction
  assign addr_byte = {SLV_PREFIX, sel_q, rd_q ? DIR_READ : DIR_WRITE};
  always_comb begin
    // Next state of the byte sequencer
    st_d = st_q;
    ph_d = ph_q;
    bit_d = bit_q;
    byte_d = byte_q;
    sh_d = sh_q;
    scl_d = scl_q;
    sdo_d = sdo_q;
    rd_d = rd_q;
    op_d = op_q;
    sel_d = sel_q;
    reg_d = reg_q;
    wd_d = wd_q;
    rdat_d = rdat_q;
    nack_d = nack_q;
    case (st_q)
      I2CM_IDLE: begin
        // Take a command
        scl_d = 1'b1;
        sdo_d = 1'b1;
        if (cmd_valid_i) begin
          op_d = cmd_op_i;
          sel_d = cmd_sel_i;
          reg_d = cmd_reg_i;
          wd_d = cmd_wdata_i;
          nack_d = 1'b0;
          rd_d = (cmd_op_i == I2CM_CMD_REREAD); // Reread skips pointer
          byte_d = 2'h0;
          ph_d = 2'h0;
          st_d = I2CM_START;
        end
      end
      I2CM_START: if (tick) begin
        // Data up, clock up, data down, clock down
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sdo_d = 1'b1;
          2'h1: scl_d = 1'b1;
          2'h2: sdo_d = 1'b0;
          default: begin
            scl_d = 1'b0;
            sh_d = addr_byte;
            bit_d = 3'h7;
            st_d = I2CM_BIT;
          end
        endcase
      end
      I2CM_BIT: if (tick) begin
        // Data set at low quarter, sampled at high
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sdo_d = (rd_q && byte_q == 2'h1) ? 1'b1 : sh_q[7];
          2'h1: scl_d = 1'b1;
          2'h2: sh_d = {sh_q[6:0], sda_in_q};
          default: begin
            scl_d = 1'b0;
            bit_d = bit_q - 3'h1;
            if (bit_q == 3'h0) st_d = I2CM_ACK;
          end
        endcase
      end
      I2CM_ACK: if (tick) begin
        // Release for slave ack, or master ack of read data
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sdo_d = !(rd_q && byte_q == 2'h1);
          2'h1: scl_d = 1'b1;
          2'h2: if (!(rd_q && byte_q == 2'h1) && sda_in_q) nack_d = 1'b1;
          default: begin
            scl_d = 1'b0;
            byte_d = byte_q + 2'h1;
            bit_d = 3'h7;
            if (nack_q) begin
              st_d = I2CM_STOP;
            end else if (rd_q && byte_q == 2'h1) begin
              rdat_d = sh_q;
              st_d = I2CM_STOP;
            end else if (byte_q == 2'h0) begin
              sh_d = rd_q ? sh_q : reg_q; // Register pointer
              st_d = I2CM_BIT; // Address ack leads into the pointer byte, or the data byte when reading
            end else if (op_q == I2CM_CMD_WRITE && byte_q == 2'h1) begin
              sh_d = wd_q;
              st_d = I2CM_BIT;
            end else if (op_q == I2CM_CMD_READ && byte_q == 2'h1) begin
              rd_d = 1'b1; // Repeated start to read
              byte_d = 2'h0;
              st_d = I2CM_START;
            end else begin
              st_d = I2CM_STOP;
            end
          end
        endcase
      end
      I2CM_STOP: if (tick) begin
        // Data low, clock up, data up
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sdo_d = 1'b0;
          2'h1: scl_d = 1'b1;
          2'h2: sdo_d = 1'b1;
          default: st_d = I2CM_DONE;
        endcase
      end
      I2CM_DONE: st_d = I2CM_IDLE;
      default: st_d = I2CM_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= I2CM_IDLE;
      ph_q <= 2'h0;
      bit_q <= 3'h7;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
      scl_q <= 1'b1;
      sdo_q <= 1'b1;
      rd_q <= 1'b0;
      op_q <= 2'h0;
      sel_q <= 2'h0;
      reg_q <= 8'h00;
      wd_q <= 8'h00;
      rdat_q <= 8'h00;
      nack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      scl_q <= scl_d;
      sdo_q <= sdo_d;
      rd_q <= rd_d;
      op_q <= op_d;
      sel_q <= sel_d;
      reg_q <= reg_d;
      wd_q <= wd_d;
      rdat_q <= rdat_d;
      nack_q <= nack_d;
    end
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready_o = (st_q == I2CM_IDLE);
  assign done_o = (st_q == I2CM_DONE);
  assign nack_o = nack_q;
  assign rdata_o = rdat_q;
  assign scl_o = 1'b0; // Open drain
  assign scl_oe_o = !scl_q;
  assign sda_o = 1'b0;
  assign sda_oe_o = !sdo_q;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  data_stable_a: assert property ((st_q == I2CM_BIT && scl_q) |-> $stable(sdo_q))
    else $error("Data moved while clock high");
  start_cond_a: assert property ((st_q == I2CM_START && $fell(sdo_q)) |-> scl_q)
    else $error("Start edge without clock high");
  stop_cond_a: assert property ((st_q == I2CM_STOP && $rose(sdo_q)) |-> scl_q)
    else $error("Stop edge without clock high");
  rstart_order_a: assert property ((st_q == I2CM_START && $rose(scl_q)) |-> sdo_q)
    else $error("Clock raised before data");
  ack_release_a: assert property ((st_q == I2CM_ACK && scl_q && !rd_q) |-> sdo_q)
    else $error("Master drove slave ack bit");
  nack_stop_a: assert property ((st_q == I2CM_ACK && nack_q && tick && ph_q == 2'h3)
    |=> st_q == I2CM_STOP)
    else $error("No stop after missing ack");
  ready_idle_a: assert property (done_o |=> cmd_ready_o)
    else $error("Not idle after finish");
  bus_free_a: assert property (cmd_ready_o |-> !scl_oe_o && !sda_oe_o)
    else $error("Bus held while idle");
  master_ack_a: assert property ((st_q == I2CM_ACK && scl_q && rd_q && byte_q == 2'h1)
    |-> !sdo_q)
    else $error("Read byte not acknowledged");
  write_cv: cover property (done_o && !nack_q && op_q == I2CM_CMD_WRITE);
  read_cv: cover property (done_o && !nack_q && op_q == I2CM_CMD_READ);
  reread_cv: cover property (done_o && op_q == I2CM_CMD_REREAD);
  nack_cv: cover property (done_o && nack_q);
endmodule

// *** bench/i2cm_slave_model.sv ***
// Behavioural two-wire register slave standing on the far side of the master.
// Assumes resolved open-drain lines with pull-ups, fed back by the bench.
`timescale 1ns/1ps
module i2cm_slave_model #(
  parameter logic [1:0] SEL = 2'h3 // Level on the address select pins
) (
  input wire logic scl_i, // Resolved clock line, only ever read here
  input wire logic sda_i, // Resolved data line
  output logic sda_oe_o // High pulls data low
);
  // ****************************************************************
  // Register set and serial state
  // ****************************************************************
  logic [7:0] regs [256]; // Byte registers
  logic [7:0] ptr = 8'h00; // Kept pointer
  logic [7:0] shf = 8'h00; // Receive shifter
  int st = 0; // 0 idle, 1 addr, 2 reg, 3 data, 4 read, 5 wait
  int cnt = 0; // Bit count in the byte
  logic oe_nx = 1'b0; // Next drive level, so the line is written once per edge
  initial begin
    sda_oe_o = 1'b0;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // Start or repeated start restarts the address phase
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    st = 1;
    cnt = 0;
    sda_oe_o = 1'b0;
  end
  // Stop ends the transfer
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    st = 0;
    sda_oe_o = 1'b0;
  end
  // Sample while clock high, MSB first
  always @(posedge scl_i) if (st != 0) begin
    if (cnt < 8) shf = {shf[6:0], sda_i};
    cnt = cnt + 1;
  end
  // Drive only after the falling edge, at ack and read bits
  always @(negedge scl_i) if (st != 0) begin
    oe_nx = 1'b0;
    if (cnt == 8) begin
      if (st == 4) begin // Read byte out, master acks it
        st = 5;
      end else if (st == 1 && shf[7:1] == {5'h12, SEL}) begin // Own address
        oe_nx = 1'b1; // Ack write or read request
        st = shf[0] ? 4 : 2;
      end else if (st == 1) begin // Foreign address: silent until start
        st = 0;
      end else if (st == 2) begin // Register address loads pointer
        ptr = shf;
        oe_nx = 1'b1;
        st = 3;
      end else if (st == 3) begin // Data byte stored and acked
        regs[ptr] = shf;
        oe_nx = 1'b1;
      end
    end else if (cnt == 9) begin
      cnt = 0;
    end
    if (st == 4 && cnt < 8) oe_nx = !regs[ptr][7 - cnt]; // Shift out
    sda_oe_o = oe_nx;
  end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the two-wire register master against a slave model.
// Assumes the design package, master and slave model are compiled first.
`timescale 1ns/1ps
module testbench;
  import i2cm_pkg::*;
  // ****************************************************************
  // Signals, lines and instances
  // ****************************************************************
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, fast_i = 1'b0, cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = 2'h0, cmd_sel_i = 2'h0;
  logic [7:0] cmd_reg_i = 8'h00, cmd_wdata_i = 8'h00, rdata_o;
  logic cmd_ready_o, done_o, nack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, slv_oe;
  wire scl = !(scl_oe_o && !scl_o); // Only the master pulls the clock
  wire sda = !(sda_oe_o && !sda_o) && !slv_oe; // Wired-AND with pull-up
  int fail_count = 0, total_checks = 0, cycles = 0, edges = 0;
  i2cm_master #(.QTR_STD(4), .QTR_FAST(2)) DUT (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .fast_i(fast_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_sel_i(cmd_sel_i),
    .cmd_reg_i(cmd_reg_i), .cmd_wdata_i(cmd_wdata_i), .done_o(done_o), .nack_o(nack_o),
    .rdata_o(rdata_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));
  i2cm_slave_model #(.SEL(2'h3)) slave (.scl_i(scl), .sda_i(sda), .sda_oe_o(slv_oe));
  always #20 sys_clk_i = !sys_clk_i;
  // Data edges while clock high: start, repeated start, stop only
  always @(sda) if (scl === 1'b1) edges = edges + 1;
  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command, then wait for its done pulse
  task automatic run_cmd(input i2cm_cmd_t op, input logic [1:0] sel, input logic [7:0] rg,
      input logic [7:0] wd, input logic fast, input logic [7:0] exp_edges);
    int n;
    @(posedge sys_clk_i);
    #1;
    cmd_op_i = op;
    cmd_sel_i = sel;
    cmd_reg_i = rg;
    cmd_wdata_i = wd;
    fast_i = fast;
    cmd_valid_i = 1'b1;
    edges = 0;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    check(8'(cmd_ready_o), 8'h00);
    n = 0;
    while (done_o !== 1'b1 && n < 3000) begin
      @(posedge sys_clk_i);
      #1;
      n = n + 1;
    end
    check(8'(done_o), 8'h01);
    check(8'(edges), exp_edges);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check({3'h0, cmd_ready_o, done_o, nack_o, scl_oe_o, sda_oe_o}, 8'h10);
    check(rdata_o, 8'h00);
    check({6'h00, scl_o, sda_o}, 8'h00);
  endtask
  task automatic t_write();
    run_cmd(I2CM_CMD_WRITE, 2'h3, 8'h6D, 8'h92, 1'b0, 8'h02);
    check(8'(nack_o), 8'h00);
    check(slave.ptr, 8'h6D);
    check(slave.regs[8'h6D], 8'h92);
  endtask
  task automatic t_read();
    run_cmd(I2CM_CMD_WRITE, 2'h3, 8'h10, 8'hA5, 1'b1, 8'h02);
    check(slave.regs[8'h10], 8'hA5);
    run_cmd(I2CM_CMD_READ, 2'h3, 8'h6D, 8'h00, 1'b1, 8'h03);
    check(8'(nack_o), 8'h00);
    check(rdata_o, 8'h92);
  endtask
  task automatic t_reread();
    run_cmd(I2CM_CMD_REREAD, 2'h3, 8'h10, 8'h00, 1'b0, 8'h02);
    check(rdata_o, 8'h92);
  endtask
  task automatic t_foreign();
    run_cmd(I2CM_CMD_WRITE, 2'h1, 8'h10, 8'hFF, 1'b1, 8'h02);
    check(8'(nack_o), 8'h01);
    check(slave.regs[8'h10], 8'hA5);
    run_cmd(I2CM_CMD_REREAD, 2'h3, 8'h00, 8'h00, 1'b1, 8'h02);
    check(8'(nack_o), 8'h00);
    check(rdata_o, 8'h92);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    t_reset();
    sys_rst_i = 1'b0;
    t_write();
    t_read();
    t_reread();
    t_foreign();
    tally_and_finish();
  end
endmodule
